// [src/fps_map.svh]
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH

// clock period and the millisecond it is counted against
`define FPS_CLK_NS        8
`define FPS_MS_NS         1000000
`define FPS_CYCLES_PER_MS (`FPS_MS_NS / `FPS_CLK_NS)

// sequencing delays in milliseconds
`define FPS_INIT_MS       11'h001
`define FPS_LOGIC_MS      11'h514
`define FPS_MEM_MS        11'h1F4
`define FPS_DN_IO_MS      11'h1F4
`define FPS_DN_MEM_MS     11'h1F4
`define FPS_BACKUP_MS     11'h5DC
`define FPS_FLASH_MS      11'h0FA
`define FPS_DEB_MS        5'h14

// register offsets
`define FPS_REG_CTRL      4'h0
`define FPS_REG_STATUS    4'h4

// control register bit positions
`define FPS_CTRL_OOS      0
`define FPS_CTRL_RQP      1
`define FPS_CTRL_FLASH    2
`define FPS_CTRL_CLRFORCE 3
`define FPS_CTRL_RESET    3'h0

`endif

// [src/fps_pkg.sv]
package fps_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_INIT,
    ST_LOGIC,
    ST_MEM,
    ST_ON,
    ST_DN_IO,
    ST_DN_MEM
  } fps_state_t;

  // ordered power outputs
  typedef struct packed {
    logic frameSupply;
    logic initSig;
    logic logicEn;
    logic memEn;
    logic ioBus;
    logic offLed;
  } fps_outs_t;

  // front panel inputs
  typedef struct packed {
    logic powerOn;
    logic powerOff;
    logic override;
    logic acoTest;
  } fps_btn_t;

endpackage : fps_pkg

// [src/fps_ms_tick.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fps_map.svh"

module fps_ms_tick #(
  parameter int CYCLES_PER_MS = `FPS_CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // one-cycle pulse each millisecond
  output logic      msTick
);

  logic [16:0] cycCnt_r;  // cycle counter
  wire         cycWrap = (cycCnt_r == 17'(CYCLES_PER_MS - 1));

  // free running divider
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      cycCnt_r <= 17'h0;
    else
      cycCnt_r <= cycWrap ? 17'h0 : cycCnt_r + 17'h1;

  assign msTick = cycWrap;

endmodule : fps_ms_tick
`default_nettype wire

// [src/fps_debounce.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fps_map.svh"

module fps_debounce #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // millisecond enable
  input  wire logic         msTick,
  // raw and cleaned levels
  input  wire logic [W-1:0] rawIn,
  output logic      [W-1:0] cleanOut
);

  genvar i;
  // one synchroniser and settle counter per input
  generate
    for (i = 0; i < W; i++)
    begin : gBit
      logic       meta_r;    // first stage, read only by sync_r
      logic       sync_r;    // second stage
      logic       stable_r;  // accepted level
      logic [4:0] cnt_r;     // settle time in ms
      wire        differ = sync_r != stable_r;
      wire        settled = msTick && (cnt_r == `FPS_DEB_MS - 5'h1);
      always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
          meta_r   <= 1'b0;
          sync_r   <= 1'b0;
          stable_r <= 1'b0;
          cnt_r    <= 5'h0;
        end
        else
        begin
          meta_r <= rawIn[i];
          sync_r <= meta_r;
          if (!differ)
            cnt_r <= 5'h0;
          else if (settled)
          begin
            stable_r <= sync_r;
            cnt_r    <= 5'h0;
          end
          else if (msTick)
            cnt_r <= cnt_r + 5'h1;
        end
      assign cleanOut[i] = stable_r;
    end
  endgenerate

endmodule : fps_debounce
`default_nettype wire

// [src/fps_sequencer.sv]
// Overview of operation
// - power-on press in off state starts power-up
// - fixed order: init phase, then three starts
// - init phase enables supply, clears control state
// - drive two converter start outputs
// - third start output enables I/O bus
// - logic power, 1300 ms, then memory power
// - memory power, 500 ms, then start output
// - off lamp lit until power-up completes
// - off press ignored unless out-of-service set
// - drop init and I/O 500 ms before memory
// - drop start output before logic power
// - off lamp dark until power-down finishes
// - off plus override bypasses service interlock
// - override runs 1500 ms backup, forces release
// - supply release drops every start output
// - on press ignored in alarm-test or powered
`timescale 1ns/10ps
`default_nettype none
`include "fps_map.svh"

module fps_sequencer #(
  parameter int CYCLES_PER_MS = `FPS_CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // front panel switches
  input  wire logic        powerOnButton,
  input  wire logic        powerOffButton,
  input  wire logic        manualOverrideButton,
  input  wire logic        alarmCutoffTestSwitch,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [31:0] regRdData,
  // power outputs
  output logic             frameSupplyEnable,
  output logic             initSignals,
  output logic             firstConverterEnable,
  output logic             secondConverterEnable,
  output logic             ioBusPowerEnable,
  // lamps
  output logic             powerOffLed,
  output logic             oosLed,
  output logic             requestPendingIndication
);

  // reset release through two flops
  logic rstMeta_r;
  logic rstSync_n_r;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      rstMeta_r   <= 1'b0;
      rstSync_n_r <= 1'b0;
    end
    else
    begin
      rstMeta_r   <= 1'b1;
      rstSync_n_r <= rstMeta_r;
    end

  // millisecond timebase
  logic msTick;

  fps_ms_tick #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) uTick (
    .clk    (clk),
    .rst_n  (rstSync_n_r),
    .msTick (msTick)
  );

  // cleaned switch levels
  fps_pkg::fps_btn_t rawBtn;
  fps_pkg::fps_btn_t btn;
  fps_pkg::fps_btn_t btnPrev_r;

  assign rawBtn = {powerOnButton, powerOffButton,
                   manualOverrideButton, alarmCutoffTestSwitch};

  fps_debounce #(
    .W (4)
  ) uDeb (
    .clk      (clk),
    .rst_n    (rstSync_n_r),
    .msTick   (msTick),
    .rawIn    (rawBtn),
    .cleanOut (btn)
  );

  // previous levels for press edges
  always_ff @(posedge clk or negedge rstSync_n_r)
    if (!rstSync_n_r)
      btnPrev_r <= '0;
    else
      btnPrev_r <= btn;

  // one pulse per press
  wire onPress  = btn.powerOn && !btnPrev_r.powerOn;
  wire offPress = btn.powerOff && !btnPrev_r.powerOff;

  // control register from software
  logic [2:0] ctrl_r;      // flash, pending, out-of-service
  logic       forced_r;    // sticky: backup timer forced release
  wire        oosInd   = ctrl_r[`FPS_CTRL_OOS];
  wire        rqpInd   = ctrl_r[`FPS_CTRL_RQP];
  wire        rqpFlash = ctrl_r[`FPS_CTRL_FLASH];

  // state and counters
  fps_pkg::fps_state_t state_r;
  fps_pkg::fps_state_t state_nxt;
  logic [10:0]         msCnt_r;      // time in current state
  logic [10:0]         backupCnt_r;  // override backup time
  logic                backupRun_r;  // backup timer active

  // step limit for the current state
  logic [10:0] stepLimit;

  always_comb
  begin
    case (state_r)
      fps_pkg::ST_INIT:   stepLimit = `FPS_INIT_MS;
      fps_pkg::ST_LOGIC:  stepLimit = `FPS_LOGIC_MS;
      fps_pkg::ST_MEM:    stepLimit = `FPS_MEM_MS;
      fps_pkg::ST_DN_IO:  stepLimit = `FPS_DN_IO_MS;
      fps_pkg::ST_DN_MEM: stepLimit = `FPS_DN_MEM_MS;
      default:            stepLimit = 11'h7FF;
    endcase
  end

  // decoded conditions
  wire stepDone  = msTick && (msCnt_r == stepLimit - 11'h1);
  wire stOff     = state_r == fps_pkg::ST_OFF;
  wire stOn      = state_r == fps_pkg::ST_ON;
  wire stRising  = (state_r == fps_pkg::ST_INIT) || (state_r == fps_pkg::ST_LOGIC)
                   || (state_r == fps_pkg::ST_MEM);
  wire overDown  = offPress && btn.override;
  wire normDown  = offPress && oosInd;
  wire startUp   = stOff && onPress && !btn.acoTest;
  wire goDown    = (stOn && (normDown || overDown)) || (stRising && overDown);
  wire backupHit = backupRun_r && msTick
                   && (backupCnt_r == `FPS_BACKUP_MS - 11'h1);
  wire forceOff  = backupHit && !stOff;

  // next state
  always_comb
  begin
    state_nxt = state_r;
    if (forceOff)
      state_nxt = fps_pkg::ST_OFF;
    else
    begin
      case (state_r)
        // waits for an accepted on press
        fps_pkg::ST_OFF:
          if (startUp)
            state_nxt = fps_pkg::ST_INIT;
        // supply up, control state cleared
        fps_pkg::ST_INIT:
          // override here: only the supply is up, drop straight to off
          if (goDown)
            state_nxt = fps_pkg::ST_OFF;
          else if (stepDone)
            state_nxt = fps_pkg::ST_LOGIC;
        // logic power settling
        fps_pkg::ST_LOGIC:
          // override here: memory never came up, skip its step
          if (goDown)
            state_nxt = fps_pkg::ST_DN_MEM;
          else if (stepDone)
            state_nxt = fps_pkg::ST_MEM;
        // memory power settling
        fps_pkg::ST_MEM:
          if (goDown)
            state_nxt = fps_pkg::ST_DN_IO;
          else if (stepDone)
            state_nxt = fps_pkg::ST_ON;
        // fully up; off press needs interlock
        fps_pkg::ST_ON:
          if (goDown)
            state_nxt = fps_pkg::ST_DN_IO;
        // init and I/O dropped, memory still on
        fps_pkg::ST_DN_IO:
          if (stepDone)
            state_nxt = fps_pkg::ST_DN_MEM;
        // memory dropped, logic still on
        fps_pkg::ST_DN_MEM:
          if (stepDone)
            state_nxt = fps_pkg::ST_OFF;
        default:
          state_nxt = fps_pkg::ST_OFF;
      endcase
    end
  end

  // output pattern of a state
  function automatic fps_pkg::fps_outs_t outsOf(input fps_pkg::fps_state_t st);
    fps_pkg::fps_outs_t o;
    o = '0;
    case (st)
      fps_pkg::ST_INIT:   o = 6'b110001;
      fps_pkg::ST_LOGIC:  o = 6'b111001;
      fps_pkg::ST_MEM:    o = 6'b111101;
      fps_pkg::ST_ON:     o = 6'b111110;
      fps_pkg::ST_DN_IO:  o = 6'b101100;
      fps_pkg::ST_DN_MEM: o = 6'b101000;
      default:            o = 6'b000001;  // off: only the lamp
    endcase
    return o;
  endfunction : outsOf

  fps_pkg::fps_outs_t outs_r;
  wire fps_pkg::fps_outs_t outs_nxt = outsOf(state_nxt);

  // state, outputs and step timer
  always_ff @(posedge clk or negedge rstSync_n_r)
    if (!rstSync_n_r)
    begin
      state_r <= fps_pkg::ST_OFF;
      outs_r  <= 6'b000001;
      msCnt_r <= 11'h0;
    end
    else
    begin
      state_r <= state_nxt;
      outs_r  <= outs_nxt;
      // restart timing on every state change
      if (state_nxt != state_r)
        msCnt_r <= 11'h0;
      else if (msTick)
        msCnt_r <= msCnt_r + 11'h1;
    end

  // backup timer for override power-down
  always_ff @(posedge clk or negedge rstSync_n_r)
    if (!rstSync_n_r)
    begin
      backupRun_r <= 1'b0;
      backupCnt_r <= 11'h0;
    end
    else if (goDown && overDown && !backupRun_r)
    begin
      backupRun_r <= 1'b1;
      backupCnt_r <= 11'h0;
    end
    else if (stOff || state_nxt == fps_pkg::ST_OFF)
      backupRun_r <= 1'b0;
    else if (backupRun_r && msTick)
      backupCnt_r <= backupCnt_r + 11'h1;

  // pending lamp flash phase
  logic [10:0] flashCnt_r;
  logic        flashPhase_r;
  wire         flashWrap = msTick && (flashCnt_r == `FPS_FLASH_MS - 11'h1);

  always_ff @(posedge clk or negedge rstSync_n_r)
    if (!rstSync_n_r)
    begin
      flashCnt_r   <= 11'h0;
      flashPhase_r <= 1'b0;
    end
    else if (flashWrap)
    begin
      flashCnt_r   <= 11'h0;
      flashPhase_r <= !flashPhase_r;
    end
    else if (msTick)
      flashCnt_r <= flashCnt_r + 11'h1;

  // register decode
  wire ctrlWr = regWrEn && (regAddr == `FPS_REG_CTRL);
  wire clrForce = ctrlWr && regWrData[`FPS_CTRL_CLRFORCE];
  wire [31:0] statusWord = {20'h0, forced_r, backupRun_r, outs_r, state_r, 1'b0};
  wire [31:0] ctrlWord = {29'h0, ctrl_r};
  wire [31:0] rdMux = (regAddr == `FPS_REG_CTRL)   ? ctrlWord :
                      (regAddr == `FPS_REG_STATUS) ? statusWord : 32'h0;

  // control, sticky flag, read data, lamps
  logic [31:0] rdData_r;
  logic        oosLed_r;
  logic        rqpLed_r;

  always_ff @(posedge clk or negedge rstSync_n_r)
    if (!rstSync_n_r)
    begin
      ctrl_r   <= `FPS_CTRL_RESET;
      forced_r <= 1'b0;
      rdData_r <= 32'h0;
      oosLed_r <= 1'b0;
      rqpLed_r <= 1'b0;
    end
    else
    begin
      if (ctrlWr)
        ctrl_r <= regWrData[2:0];
      // set wins over clear
      if (forceOff)
        forced_r <= 1'b1;
      else if (clrForce)
        forced_r <= 1'b0;
      rdData_r <= regRdEn ? rdMux : 32'h0;
      oosLed_r <= oosInd;
      rqpLed_r <= rqpInd && (!rqpFlash || flashPhase_r);
    end

  // ports from flops
  assign regRdData                = rdData_r;
  assign frameSupplyEnable        = outs_r.frameSupply;
  assign initSignals              = outs_r.initSig;
  assign firstConverterEnable     = outs_r.logicEn;
  assign secondConverterEnable    = outs_r.memEn;
  assign ioBusPowerEnable         = outs_r.ioBus;
  assign powerOffLed              = outs_r.offLed;
  assign oosLed                   = oosLed_r;
  assign requestPendingIndication = rqpLed_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_n_r);

  chk_on_starts: assert property (startUp |=> state_r == fps_pkg::ST_INIT)
    else $error("on press did not start power-up");
  chk_on_ignored: assert property (
    onPress && (btn.acoTest || !stOff) && !goDown && !forceOff && !stepDone
    |=> $stable(state_r))
    else $error("on press changed state when it must not");
  chk_mem_delay: assert property ($rose(secondConverterEnable) |->
    $past(msCnt_r) == `FPS_LOGIC_MS - 11'h1 && $past(firstConverterEnable))
    else $error("memory power not 1300 ms after logic power");
  chk_start_delay: assert property ($rose(ioBusPowerEnable) |->
    $past(msCnt_r) == `FPS_MEM_MS - 11'h1 && secondConverterEnable)
    else $error("start output not 500 ms after memory power");
  chk_off_lamp_up: assert property ($fell(powerOffLed) |->
    ioBusPowerEnable || state_r == fps_pkg::ST_DN_IO || state_r == fps_pkg::ST_DN_MEM)
    else $error("off lamp dropped before power-up completed");
  chk_off_lamp_lit: assert property (stOff |-> powerOffLed)
    else $error("off lamp dark in power-off state");
  chk_off_interlock: assert property (stOn && offPress && !oosInd && !btn.override
    && !forceOff |=> stOn)
    else $error("off press acted without out-of-service");
  chk_dn_mem_order: assert property ($fell(secondConverterEnable) && !$past(forceOff)
    |-> !initSignals && !ioBusPowerEnable && $past(msCnt_r) == `FPS_DN_IO_MS - 11'h1)
    else $error("memory power removed out of order");
  chk_dn_lamp_dark: assert property ((state_r == fps_pkg::ST_DN_IO
    || state_r == fps_pkg::ST_DN_MEM) |-> !powerOffLed)
    else $error("off lamp lit during power-down");
  chk_override_down: assert property (stOn && overDown && !forceOff
    |=> state_r == fps_pkg::ST_DN_IO ##0 backupRun_r)
    else $error("override did not start power-down");
  chk_backup_force: assert property (forceOff |=> stOff && !frameSupplyEnable
    && forced_r)
    else $error("backup timeout did not force release");
  chk_supply_drop: assert property (!frameSupplyEnable |-> !firstConverterEnable
    && !secondConverterEnable && !ioBusPowerEnable && !initSignals)
    else $error("start output active without frame supply");

endmodule : fps_sequencer
`default_nettype wire

// [dv/fps_panel_model.sv]
`timescale 1ns/10ps
`default_nettype none

module fps_panel_model (
  // clock
  input  wire logic        clk,
  // panel switches
  output logic             powerOnButton,
  output logic             powerOffButton,
  output logic             manualOverrideButton,
  output logic             alarmCutoffTestSwitch,
  // register port of system software
  output logic      [3:0]  regAddr,
  output logic      [31:0] regWrData,
  output logic             regWrEn,
  output logic             regRdEn,
  input  wire logic [31:0] regRdData
);
  // idle panel: contacts open, pulled low
  initial
  begin
    {powerOnButton, powerOffButton, manualOverrideButton, alarmCutoffTestSwitch} = 4'h0;
    regAddr   = 4'h0;
    regWrData = 32'h0;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
  end

  // close the switches {on, off, override, aco}
  task automatic push(input logic [3:0] b);
    @(posedge clk);
    {powerOnButton, powerOffButton, manualOverrideButton, alarmCutoffTestSwitch} <= b;
  endtask : push

  // open all switches
  task automatic rel();
    push(4'h0);
  endtask : rel

  // press for 30 ms, then rest 30 ms so the debouncer sees both edges
  task automatic tap(input logic [3:0] b);
    push(b);
    repeat (300) @(posedge clk);
    rel();
    repeat (300) @(posedge clk);
  endtask : tap

  // one-cycle write; data line scrambled once released
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge clk);
    regWrEn   <= 1'b0;
    regWrData <= ~d;
  endtask : reg_write

  // one-cycle read; data taken in the following cycle only
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
  endtask : reg_read

  // software indication points: 0 normal, 1 pending, 2 denied, 3 diag fail, 4 granted
  task automatic indicate(input int code);
    logic [31:0] v;
    case (code)
      1:       v = 32'h2;
      2:       v = 32'h6;
      3:       v = 32'h7;
      4:       v = 32'h1;
      default: v = 32'h0;
    endcase
    reg_write(4'h0, v);
  endtask : indicate

endmodule : fps_panel_model

`default_nettype wire

// [dv/frame_power_sequencer_test.sv]
`timescale 1ns/10ps
`default_nettype none

module frame_power_sequencer_test;
  // clock, reset and design wires
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        powerOnButton, powerOffButton, manualOverrideButton, alarmCutoffTestSwitch;
  logic [3:0]  regAddr;
  logic [31:0] regWrData, regRdData, rd;
  logic        regWrEn, regRdEn;
  logic        frameSupplyEnable, initSignals, firstConverterEnable;
  logic        secondConverterEnable, ioBusPowerEnable, powerOffLed, oosLed;
  logic        requestPendingIndication;
  logic [5:0]  outs;
  int          fails = 0;
  int          check_count = 0;
  int          n;
  // refused presses in the off state: {on, off, override, aco} beside the outputs left
  logic [9:0]  rows [3] = '{{4'h4, 6'h01}, {4'h9, 6'h01}, {4'h6, 6'h01}};

  // bit 5 supply .. bit 0 off lamp
  assign outs = {frameSupplyEnable, initSignals, firstConverterEnable,
                 secondConverterEnable, ioBusPowerEnable, powerOffLed};

  // 8 ns clock
  always #4 clk = ~clk;

  fps_sequencer #(.CYCLES_PER_MS(10)) u_fps_sequencer (
    .clk(clk), .rst_n(rst_n),
    .powerOnButton(powerOnButton), .powerOffButton(powerOffButton),
    .manualOverrideButton(manualOverrideButton),
    .alarmCutoffTestSwitch(alarmCutoffTestSwitch),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData),
    .frameSupplyEnable(frameSupplyEnable), .initSignals(initSignals),
    .firstConverterEnable(firstConverterEnable),
    .secondConverterEnable(secondConverterEnable),
    .ioBusPowerEnable(ioBusPowerEnable), .powerOffLed(powerOffLed),
    .oosLed(oosLed), .requestPendingIndication(requestPendingIndication)
  );

  fps_panel_model u_fps_panel_model (
    .clk(clk),
    .powerOnButton(powerOnButton), .powerOffButton(powerOffButton),
    .manualOverrideButton(manualOverrideButton),
    .alarmCutoffTestSwitch(alarmCutoffTestSwitch),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData)
  );

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // cycles until output idx reaches v, bounded
  task automatic wait_out(input int idx, input logic v, output int cnt);
    cnt = 0;
    while (outs[idx] !== v && cnt < 30000)
    begin
      @(negedge clk);
      cnt++;
    end
    // a wait that runs out is a mismatch
    if (cnt >= 30000)
      fails++;
  endtask : wait_out

  // a span of clock cycles at 10 per ms, with 1.5 ms of slack below and 0.5 ms above
  task automatic span(input string nm, input int cnt, input int ms);
    chk(nm, 32'((cnt >= ms * 10 - 15) && (cnt <= ms * 10 + 5)), 32'h1);
  endtask : span

  // press on and follow the whole power-up
  task automatic power_up();
    u_fps_panel_model.push(4'h8);
    wait_out(5, 1'b1, n);
    chk("init phase", outs, 6'h31);
    wait_out(3, 1'b1, n);
    chk("logic on", outs, 6'h39);
    wait_out(2, 1'b1, n);
    span("logic to mem", n, 1300);
    u_fps_panel_model.rel();
    wait_out(1, 1'b1, n);
    span("mem to start", n, 500);
    chk("up done", outs, 6'h3E);
  endtask : power_up

  // follow the whole power-down once the off press is accepted
  task automatic power_down(input logic [3:0] b);
    u_fps_panel_model.push(b);
    wait_out(1, 1'b0, n);
    chk("io off", outs, 6'h2C);
    wait_out(2, 1'b0, n);
    span("io to mem", n, 500);
    chk("mem off", outs, 6'h28);
    wait_out(3, 1'b0, n);
    span("mem to logic", n, 500);
    chk("down done", outs, 6'h01);
    u_fps_panel_model.rel();
    repeat (300) @(posedge clk);
  endtask : power_down

  // verdict
  task automatic close_out();
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // watchdog sized for about 80k cycles of tests
  initial
  begin
    repeat (95000) @(posedge clk);
    fails++;
    close_out();
  end

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk("reset outs", outs, 6'h01);
    u_fps_panel_model.reg_read(4'h0, rd);
    chk("ctrl reset", rd, 32'h0);
    u_fps_panel_model.reg_read(4'h4, rd);
    chk("status off", rd, 32'h10);
    u_fps_panel_model.reg_write(4'h8, 32'hF);
    u_fps_panel_model.reg_read(4'h8, rd);
    chk("unmapped", rd, 32'h0);
    u_fps_panel_model.reg_write(4'h0, 32'hF);
    u_fps_panel_model.reg_read(4'h0, rd);
    chk("ctrl rw", rd, 32'h7);
    u_fps_panel_model.reg_write(4'h0, 32'h0);
    // refused presses while off
    foreach (rows[i])
    begin
      u_fps_panel_model.tap(rows[i][9:6]);
      chk("refused press", outs, rows[i][5:0]);
    end
    power_up();
    // presses while up, no service grant
    u_fps_panel_model.tap(4'h8);
    u_fps_panel_model.tap(4'h4);
    u_fps_panel_model.reg_read(4'h4, rd);
    chk("stays on", rd, 32'h3E8);
    u_fps_panel_model.indicate(4);
    power_down(4'h4);
    power_up();
    u_fps_panel_model.indicate(0);
    power_down(4'h6);
    u_fps_panel_model.reg_read(4'h4, rd);
    chk("no forced release", rd & 32'h800, 32'h0);
    // override while logic power settles: memory never comes up
    u_fps_panel_model.push(4'h8);
    wait_out(3, 1'b1, n);
    u_fps_panel_model.push(4'h6);
    wait_out(0, 1'b0, n);
    chk("override in up", outs, 6'h28);
    u_fps_panel_model.reg_read(4'h4, rd);
    chk("override status", rd, 32'h68C);
    wait_out(5, 1'b0, n);
    span("override drop", n, 500);
    chk("override off", outs, 6'h01);
    u_fps_panel_model.rel();
    repeat (300) @(posedge clk);
    // every software indication state
    for (int c = 0; c < 5; c++)
    begin
      u_fps_panel_model.indicate(c);
      repeat (3) @(negedge clk);
      chk("oos lamp", 32'(oosLed), 32'((c == 3) || (c == 4)));
      if (c == 2 || c == 3)
      begin
        n = 0;
        for (int k = 0; k < 60; k++)
        begin
          repeat (100) @(negedge clk);
          n += (requestPendingIndication === 1'b1) ? 1 : 0;
        end
        chk("pending flashes", 32'((n > 10) && (n < 50)), 32'h1);
      end
      else
        chk("pending lamp", 32'(requestPendingIndication), 32'(c == 1));
    end
    // reset in mid power-up drops every power output, lights the off lamp and clears control
    u_fps_panel_model.push(4'h8);
    wait_out(3, 1'b1, n);
    u_fps_panel_model.rel();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("reset mid", outs, 6'h01);
    repeat (300) @(posedge clk);
    u_fps_panel_model.reg_read(4'h0, rd);
    chk("ctrl after reset", rd, 32'h0);
    chk("off after reset", outs, 6'h01);
    close_out();
  end

endmodule : frame_power_sequencer_test

`default_nettype wire
